// ### bench/dtc_top_tb.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_top_tb;
  localparam logic [7:0] a_ctl = `DTC_ADDR_CTRL;
  localparam logic [7:0] a_mod = `DTC_ADDR_MODE;
  localparam logic [7:0] a_aux = `DTC_ADDR_AUX;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [1:0] ack;
  logic [1:0] cpin;
  logic [1:0] gate;
  logic [1:0] irq;
  logic [1:0] cko;
  logic [1:0] oe;
  logic p [8];
  int mismatches;
  int samples_checked;
  logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
    8'ha3, 8'h90};

  dtc_top u_dut (
    .i_sys_clk(clk),
    .i_rst_n(rst_n),
    .i_sfr_addr(addr),
    .i_sfr_wr(wr),
    .i_sfr_rd(rd),
    .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata),
    .i_vec_ack_zero(ack[0]),
    .i_vec_ack_one(ack[1]),
    .i_count_pin_zero(cpin[0]),
    .i_count_pin_one(cpin[1]),
    .i_gate_pin_zero(gate[0]),
    .i_gate_pin_one(gate[1]),
    .o_irq_zero(irq[0]),
    .o_irq_one(irq[1]),
    .o_unit_zero_clock_output_pin(cko[0]),
    .o_unit_zero_clock_output_oe(oe[0]),
    .o_unit_one_clock_output_pin(cko[1]),
    .o_unit_one_clock_output_oe(oe[1])
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Bus tasks and comparison
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Load a unit, open its gate for m cycles (or m pin pulses), check
  task automatic run(input int u, input logic [3:0] mb, input logic fast,
      input logic [7:0] th, input logic [7:0] tl, input logic go,
      input int m, input logic [7:0] etl, input logic [7:0] eth,
      input logic [1:0] ef);
    logic [7:0] ta;
    logic [7:0] ha;
    ta = u[0] ? `DTC_ADDR_LOW1 : `DTC_ADDR_LOW0;
    ha = u[0] ? `DTC_ADDR_HIGH1 : `DTC_ADDR_HIGH0;
    wr_reg(a_ctl, 8'h00);
    wr_reg(a_mod, u[0] ? {mb, 4'h0} : {4'h0, mb});
    wr_reg(a_aux, {4'h0, fast & u[0], fast & ~u[0], 2'b00});
    wr_reg(ha, th);
    wr_reg(ta, tl);
    wr_reg(a_ctl, {1'b0, go & u[0], 1'b0, go & ~u[0], 4'h0});
    @(posedge clk);
    gate[u] <= 1'b1;
    if (mb[2])
    begin
      repeat (m)
      begin
        cpin[u] <= 1'b1;
        repeat (30) @(posedge clk);
        cpin[u] <= 1'b0;
        repeat (30) @(posedge clk);
      end
    end
    else
      repeat (m) @(posedge clk);
    gate[u] <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(ta, etl);
    rd_reg(ha, eth);
    rd_reg(a_ctl, u[0] ? {ef, 6'h00} : {2'b00, ef, 4'h0});
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    ack = 2'b00;
    cpin = 2'b00;
    gate = 2'b00;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i])
      rd_reg(regs[i], 8'h00);
    wr_reg(a_ctl, 8'haf);
    rd_reg(a_ctl, 8'ha0);
    check(irq, 2'b11);
    @(posedge clk);
    ack <= 2'b01;
    @(posedge clk);
    ack <= 2'b00;
    rd_reg(a_ctl, 8'h80);
    @(posedge clk);
    ack <= 2'b10;
    @(posedge clk);
    ack <= 2'b00;
    rd_reg(a_ctl, 8'h00);
    wr_reg(a_mod, 8'h5a);
    rd_reg(a_mod, 8'h5a);
    wr_reg(a_aux, 8'hf3);
    rd_reg(a_aux, 8'h03);
    check(oe, 2'b11);
    wr_reg(a_aux, 8'h00);
    rd_reg(a_aux, 8'h00);
    check(oe, 2'b00);
    for (int u = 0; u < 2; u++)
    begin
      run(u, 4'ha, 1, 8'hfc, 8'hfc, 1, 5, 8'hfd, 8'hfc, 2'b11);
      run(u, 4'ha, 0, 8'h10, 8'h10, 1, 24, 8'h12, 8'h10, 2'b01);
      run(u, 4'h9, 1, 8'h12, 8'hfe, 1, 3, 8'h01, 8'h13, 2'b01);
      run(u, 4'h8, 1, 8'hff, 8'hfe, 1, 3, 8'he1, 8'h00, 2'b11);
      run(u, 4'h8, 1, 8'h00, 8'h00, 0, 9, 8'h00, 8'h00, 2'b00);
      run(u, 4'hd, 1, 8'h00, 8'h00, 1, 3, 8'h03, 8'h00, 2'b01);
      wr_reg(a_mod, 8'h00);
      wr_reg(a_aux, u[0] ? 8'h0a : 8'h05);
      wr_reg(u[0] ? `DTC_ADDR_HIGH1 : `DTC_ADDR_HIGH0, 8'hfe);
      wr_reg(u[0] ? `DTC_ADDR_LOW1 : `DTC_ADDR_LOW0, 8'hfe);
      wr_reg(a_ctl, u[0] ? 8'h40 : 8'h10);
      repeat (4) @(posedge clk);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge clk);
        #1;
        p[k] = cko[u];
        if (k > 1)
          check(p[k] ^ p[k - 2], 8'h01);
      end
      check(oe[u], 8'h01);
      check(irq[u], 8'h00);
    end
    run(1, 4'hb, 1, 8'h05, 8'h07, 1, 10, 8'h07, 8'h05, 2'b01);
    run(0, 4'hb, 1, 8'h40, 8'hfe, 1, 3, 8'h01, 8'h40, 2'b11);
    wr_reg(`DTC_ADDR_HIGH0, 8'hff);
    wr_reg(a_ctl, 8'h40);
    @(posedge clk);
    #1;
    check(irq[1], 8'h01);
    wr_reg(a_ctl, 8'h00);
    rd_reg(`DTC_ADDR_HIGH0, 8'h02);
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule

// ### design/dtc_defines.svh
// Register addresses, bit positions and counts for the dual timer block
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_LOW0 8'h8a
`define DTC_ADDR_LOW1 8'h8b
`define DTC_ADDR_HIGH0 8'h8c
`define DTC_ADDR_HIGH1 8'h8d
`define DTC_ADDR_AUX 8'ha3
`define DTC_RST_BYTE 8'h00
`define DTC_RST_NIB 4'h0
`define DTC_CTRL_FLAG1 7
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_FLAG0 5
`define DTC_CTRL_RUN0 4
`define DTC_MODE_GATE1 7
`define DTC_MODE_CT1 6
`define DTC_MODE_U1_HI 5
`define DTC_MODE_U1_LO 4
`define DTC_MODE_GATE0 3
`define DTC_MODE_CT0 2
`define DTC_MODE_U0_HI 1
`define DTC_MODE_U0_LO 0
`define DTC_AUX_X12_1 3
`define DTC_AUX_X12_0 2
`define DTC_AUX_CKOE1 1
`define DTC_AUX_CKOE0 0
`define DTC_M_13BIT 2'b00
`define DTC_M_16BIT 2'b01
`define DTC_M_RELOAD 2'b10
`define DTC_M_SPLIT 2'b11
`define DTC_PRESC_LAST 4'hb
`define DTC_PRESC_ZERO 4'h0
`define DTC_PRESC_STEP 4'h1
`define DTC_BYTE_ONES 8'hff
`define DTC_BYTE_ONE 8'h01
`define DTC_WORD_ONE 16'h0001
`define DTC_LOW5_ONES 5'h1f
`define DTC_LOW5_ONE 5'h01
`endif

// ### design/dtc_pkg.sv
// State type of the dual timer block
package dtc_pkg;
  typedef struct packed {
    logic tf1;
    logic tr1;
    logic tf0;
    logic tr0;
    logic [7:0] mode;
    logic [3:0] aux;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [3:0] presc;
    logic smp0;
    logic smp1;
    logic pend0;
    logic pend1;
    logic cko0;
    logic cko1;
    logic oe0;
    logic oe1;
    logic irq0;
    logic irq1;
    logic [7:0] rdata;
  } dtc_state_s;
endpackage

// ### design/dtc_top.sv
// Dual timer/counter with clock outputs, special-function-register port
//
// What this block does
// (R1) Unit one flag: hardware sets on overflow, vector or software clears.
// (R2) Unit zero flag: hardware sets on overflow, vector or software clears.
// (R3) Unit one counts only while its run bit is one.
// (R4) Unit zero counts only while its run bit is one, except its mode 11 high byte, which follows the unit one run bit.
// (R5) With gating on, a unit counts only while its gate pin is high, except the split high byte, which ignores both gate pins.
// (R6) Select bit zero counts the system clock, one counts pin events.
// (R7) Mode 00 is a 13-bit counter, same for both units.
// (R8) Mode 01 is a full 16-bit counter over both bytes.
// (R9) Mode 10 is an 8-bit low byte reloading from the high byte.
// (R10) Mode 11 on unit zero: two 8-bit counters, high byte timer only.
// (R11) Mode 11 on unit one stops it and holds its count.
// (R12) Unit one timer rate is clock over twelve, or clock when fast.
// (R13) Unit zero timer rate is clock over twelve, or clock when fast.
// (R14) Unit one clock output enable drives its clock onto its pin.
// (R15) Unit zero clock output enable drives its clock onto its pin.
// (R16) Pin sampled each rate cycle; high then low counts one cycle later.
// (R17) Reload overflow sets flag, copies high into low, keeps high.
// (R18) Split high byte uses unit one run bit, flag and interrupt.
// (R19) Clock output: reload timer, half-period per overflow, no interrupt.
// (R20) 13-bit count is high byte plus low five bits of low byte.
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_top
  import dtc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_vec_ack_zero,
  input wire logic i_vec_ack_one,
  input wire logic i_count_pin_zero,
  input wire logic i_count_pin_one,
  input wire logic i_gate_pin_zero,
  input wire logic i_gate_pin_one,
  output logic o_irq_zero,
  output logic o_irq_one,
  output logic o_unit_zero_clock_output_pin,
  output logic o_unit_zero_clock_output_oe,
  output logic o_unit_one_clock_output_pin,
  output logic o_unit_one_clock_output_oe
);

  dtc_state_s r_reg;
  dtc_state_s r_next;
  logic tick12;
  logic rate0;
  logic rate1;
  logic run0;
  logic run1;
  logic en0;
  logic en1;
  logic split0;
  logic cko_on0;
  logic cko_on1;
  logic [1:0] m0e;
  logic [1:0] m1e;
  logic [16:0] step0;
  logic [16:0] step1;
  logic ovf0;
  logic ovf1;
  logic en_th0;
  logic ovf_th0;
  logic wr_ctrl;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;

  // ==========================================================
  // Count step: {overflow, high, low}
  function automatic logic [16:0] dtc_step(
    input logic [1:0] mode,
    input logic [7:0] th,
    input logic [7:0] tl
  );
    logic [12:0] c13;
    logic [15:0] c16;
    c13 = {th, tl[4:0]};
    c16 = {th, tl};
    unique case (mode)
      `DTC_M_13BIT:
      begin
        c13 = c13 + {8'h00, `DTC_LOW5_ONE}; // R7 R20
        dtc_step = {(th == `DTC_BYTE_ONES) && (tl[4:0] == `DTC_LOW5_ONES),
                    c13[12:5], tl[7:5], c13[4:0]};
      end
      `DTC_M_16BIT:
      begin
        c16 = c16 + `DTC_WORD_ONE; // R8
        dtc_step = {(c16 == 16'h0000), c16};
      end
      `DTC_M_RELOAD:
      begin
        if (tl == `DTC_BYTE_ONES)
          dtc_step = {1'b1, th, th}; // R9 R17
        else
          dtc_step = {1'b0, th, tl + `DTC_BYTE_ONE};
      end
      `DTC_M_SPLIT:
      begin
        dtc_step = {(tl == `DTC_BYTE_ONES), th, tl + `DTC_BYTE_ONE}; // R10
      end
    endcase
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    r_next = r_reg;
    wr_ctrl = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_CTRL);
    wr_tl0 = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_LOW0);
    wr_th0 = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_HIGH0);
    wr_tl1 = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_LOW1);
    wr_th1 = i_sfr_wr && (i_sfr_addr == `DTC_ADDR_HIGH1);

    // Shared divide-by-twelve prescaler
    tick12 = (r_reg.presc == `DTC_PRESC_LAST);
    r_next.presc = tick12 ? `DTC_PRESC_ZERO
                          : r_reg.presc + `DTC_PRESC_STEP;
    rate0 = r_reg.aux[`DTC_AUX_X12_0] | tick12; // R13
    rate1 = r_reg.aux[`DTC_AUX_X12_1] | tick12; // R12

    // Falling edge sampled per rate cycle, counted on the next one
    if (rate0)
    begin
      r_next.smp0 = i_count_pin_zero; // R16
      r_next.pend0 = r_reg.smp0 & ~i_count_pin_zero; // R16
    end
    if (rate1)
    begin
      r_next.smp1 = i_count_pin_one;
      r_next.pend1 = r_reg.smp1 & ~i_count_pin_one;
    end

    cko_on0 = r_reg.aux[`DTC_AUX_CKOE0] & ~r_reg.mode[`DTC_MODE_CT0];
    cko_on1 = r_reg.aux[`DTC_AUX_CKOE1] & ~r_reg.mode[`DTC_MODE_CT1];
    m0e = cko_on0 ? `DTC_M_RELOAD
                  : r_reg.mode[`DTC_MODE_U0_HI:`DTC_MODE_U0_LO]; // R19
    m1e = cko_on1 ? `DTC_M_RELOAD
                  : r_reg.mode[`DTC_MODE_U1_HI:`DTC_MODE_U1_LO]; // R19
    split0 = (m0e == `DTC_M_SPLIT);

    run0 = r_reg.tr0 &
           (~r_reg.mode[`DTC_MODE_GATE0] | i_gate_pin_zero); // R4 R5
    run1 = r_reg.tr1 &
           (~r_reg.mode[`DTC_MODE_GATE1] | i_gate_pin_one); // R3 R5
    en0 = run0 & rate0 &
          (r_reg.mode[`DTC_MODE_CT0] ? r_reg.pend0 : 1'b1); // R6
    en1 = run1 & rate1 & (m1e != `DTC_M_SPLIT) &
          (r_reg.mode[`DTC_MODE_CT1] ? r_reg.pend1 : 1'b1); // R6 R11

    step0 = dtc_step(m0e, r_reg.th0, r_reg.tl0);
    step1 = dtc_step(m1e, r_reg.th1, r_reg.tl1);
    ovf0 = en0 & step0[16];
    ovf1 = en1 & step1[16];
    if (en0)
    begin
      r_next.tl0 = step0[7:0];
      r_next.th0 = step0[15:8];
    end
    if (en1)
    begin
      r_next.tl1 = step1[7:0];
      r_next.th1 = step1[15:8];
    end

    // Split high byte: timer only, unit one run bit
    en_th0 = split0 & r_reg.tr1 & rate0; // R10 R18
    ovf_th0 = en_th0 & (r_reg.th0 == `DTC_BYTE_ONES);
    if (en_th0)
      r_next.th0 = r_reg.th0 + `DTC_BYTE_ONE;

    // Clock outputs toggle on each overflow
    if (ovf0 & cko_on0)
      r_next.cko0 = ~r_reg.cko0; // R15 R19
    if (ovf1 & cko_on1)
      r_next.cko1 = ~r_reg.cko1; // R14 R19

    // Flags: vector clear, software write, then hardware set wins
    r_next.tf0 = r_reg.tf0 & ~i_vec_ack_zero; // R2
    r_next.tf1 = r_reg.tf1 & ~i_vec_ack_one; // R1
    if (wr_ctrl)
    begin
      r_next.tf1 = i_sfr_wdata[`DTC_CTRL_FLAG1];
      r_next.tr1 = i_sfr_wdata[`DTC_CTRL_RUN1]; // R3
      r_next.tf0 = i_sfr_wdata[`DTC_CTRL_FLAG0];
      r_next.tr0 = i_sfr_wdata[`DTC_CTRL_RUN0]; // R4
    end
    r_next.tf0 = r_next.tf0 | ovf0; // R2
    r_next.tf1 = r_next.tf1 | (split0 ? ovf_th0 : ovf1); // R1 R18

    // Software writes to count bytes override counting
    if (i_sfr_wr && (i_sfr_addr == `DTC_ADDR_MODE))
      r_next.mode = i_sfr_wdata;
    if (i_sfr_wr && (i_sfr_addr == `DTC_ADDR_AUX))
      r_next.aux = i_sfr_wdata[3:0];
    if (wr_tl0)
      r_next.tl0 = i_sfr_wdata;
    if (wr_th0)
      r_next.th0 = i_sfr_wdata;
    if (wr_tl1)
      r_next.tl1 = i_sfr_wdata;
    if (wr_th1)
      r_next.th1 = i_sfr_wdata;

    r_next.oe0 = r_next.aux[`DTC_AUX_CKOE0]; // R15
    r_next.oe1 = r_next.aux[`DTC_AUX_CKOE1]; // R14
    r_next.irq0 = r_next.tf0 & ~cko_on0; // R19
    r_next.irq1 = r_next.tf1 & (split0 | ~cko_on1); // R18 R19

    if (i_sfr_rd)
    begin
      unique case (i_sfr_addr)
        `DTC_ADDR_CTRL: r_next.rdata = {r_reg.tf1, r_reg.tr1, r_reg.tf0,
                                        r_reg.tr0, `DTC_RST_NIB};
        `DTC_ADDR_MODE: r_next.rdata = r_reg.mode;
        `DTC_ADDR_LOW0: r_next.rdata = r_reg.tl0;
        `DTC_ADDR_HIGH0: r_next.rdata = r_reg.th0;
        `DTC_ADDR_LOW1: r_next.rdata = r_reg.tl1;
        `DTC_ADDR_HIGH1: r_next.rdata = r_reg.th1;
        `DTC_ADDR_AUX: r_next.rdata = {`DTC_RST_NIB, r_reg.aux};
        default: r_next.rdata = `DTC_RST_BYTE;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign o_sfr_rdata = r_reg.rdata;
  assign o_irq_zero = r_reg.irq0;
  assign o_irq_one = r_reg.irq1;
  assign o_unit_zero_clock_output_pin = r_reg.cko0;
  assign o_unit_zero_clock_output_oe = r_reg.oe0;
  assign o_unit_one_clock_output_pin = r_reg.cko1;
  assign o_unit_one_clock_output_oe = r_reg.oe1;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_reload_wrap;
    en0 && (m0e == `DTC_M_RELOAD) && (r_reg.tl0 == `DTC_BYTE_ONES) &&
    !wr_tl0 && !wr_th0;
  endsequence

  sequence s_split_wrap;
    en_th0 && (r_reg.th0 == `DTC_BYTE_ONES) && !wr_ctrl;
  endsequence

  a_zero_flag_set: assert property (ovf0 |=> r_reg.tf0) // R2
    else $error("unit zero flag not set on overflow");
  a_one_flag_clear: assert property (i_vec_ack_one && !wr_ctrl &&
    !ovf1 && !ovf_th0 |=> !r_reg.tf1) // R1
    else $error("unit one flag not cleared by vector");
  a_zero_run_off: assert property (!r_reg.tr0 && !wr_tl0
    |=> $stable(r_reg.tl0)) // R4
    else $error("unit zero counted while stopped");
  a_one_run_off: assert property (!r_reg.tr1 && !wr_tl1
    |=> $stable(r_reg.tl1)) // R3
    else $error("unit one counted while stopped");
  a_gate_low_hold: assert property (r_reg.mode[`DTC_MODE_GATE0] &&
    !i_gate_pin_zero && !wr_tl0 |=> $stable(r_reg.tl0)) // R5
    else $error("unit zero counted with gate low");
  a_slow_rate_tick: assert property (en0 && !r_reg.aux[`DTC_AUX_X12_0]
    |-> r_reg.presc == `DTC_PRESC_LAST) // R13
    else $error("unit zero counted off the slow rate");
  a_reload_copy: assert property (s_reload_wrap |=> (r_reg.tl0 ==
    $past(r_reg.th0)) && $stable(r_reg.th0) && r_reg.tf0) // R17
    else $error("reload did not copy high byte");
  a_split_flag: assert property (s_split_wrap |=> r_reg.tf1) // R18
    else $error("split high byte did not set unit one flag");
  a_one_mode3_hold: assert property ((m1e == `DTC_M_SPLIT) && !wr_tl1 &&
    !wr_th1 |=> $stable(r_reg.tl1) && $stable(r_reg.th1)) // R11
    else $error("unit one moved in mode three");
  a_clkout_toggle: assert property (ovf0 && cko_on0 |=> (r_reg.cko0 !=
    $past(r_reg.cko0)) && !r_reg.irq0) // R19
    else $error("clock output did not toggle quietly");
  a_edge_pending: assert property (rate0 && r_reg.smp0 &&
    !i_count_pin_zero |=> r_reg.pend0) // R16
    else $error("falling edge not detected");

  // ==========================================================
  // Unit one, unit zero and counting-path assertions
  a_one_flag_set: assert property ( // R1
    ovf1 && !split0 |=> r_reg.tf1)
    else $error("unit one flag not set on overflow");
  a_zero_flag_clear: assert property ( // R2
    i_vec_ack_zero && !wr_ctrl && !ovf0 |=> !r_reg.tf0)
    else $error("unit zero flag not cleared by vector");
  a_zero_run_gated: assert property (en0 |-> r_reg.tr0) // R4
    else $error("unit zero stepped without run bit");
  a_one_run_gated: assert property (en1 |-> r_reg.tr1) // R3
    else $error("unit one stepped without run bit");
  a_gate_one_hold: assert property ( // R5
    r_reg.mode[`DTC_MODE_GATE1] && !i_gate_pin_one && !wr_tl1
    |=> $stable(r_reg.tl1))
    else $error("unit one counted with gate low");
  a_one_slow_tick: assert property ( // R12
    en1 && !r_reg.aux[`DTC_AUX_X12_1] |-> r_reg.presc == `DTC_PRESC_LAST)
    else $error("unit one counted off the slow rate");
  a_pin_count_gate: assert property ( // R6
    r_reg.mode[`DTC_MODE_CT0] && !r_reg.pend0 && !wr_tl0
    |=> $stable(r_reg.tl0))
    else $error("counter stepped without a pin edge");
  a_wide_carry: assert property ( // R8
    en0 && (m0e == `DTC_M_16BIT) && (r_reg.tl0 == `DTC_BYTE_ONES) &&
    !wr_th0 |=> r_reg.th0 == $past(r_reg.th0) + `DTC_BYTE_ONE)
    else $error("16-bit carry into high byte lost");
  a_narrow_carry: assert property ( // R20
    en0 && (m0e == `DTC_M_13BIT) && (r_reg.tl0[4:0] == `DTC_LOW5_ONES) &&
    !wr_th0 && !wr_tl0 |=> (r_reg.th0 == $past(r_reg.th0) +
    `DTC_BYTE_ONE) && (r_reg.tl0[7:5] == $past(r_reg.tl0[7:5])))
    else $error("13-bit carry wrong");
  a_split_run_off: assert property ( // R10
    split0 && !r_reg.tr1 && !wr_th0 |=> $stable(r_reg.th0))
    else $error("split high byte ran without unit one run bit");
  a_reload_one_copy: assert property ( // R17
    en1 && (m1e == `DTC_M_RELOAD) && (r_reg.tl1 == `DTC_BYTE_ONES) &&
    !wr_tl1 && !wr_th1 && !split0 |=> (r_reg.tl1 == $past(r_reg.th1)) &&
    $stable(r_reg.th1) && r_reg.tf1)
    else $error("unit one reload did not copy high byte");
  a_oe_zero_follow: assert property ( // R15
    r_reg.oe0 == r_reg.aux[`DTC_AUX_CKOE0])
    else $error("unit zero output enable wrong");
  a_oe_one_follow: assert property ( // R14
    r_reg.oe1 == r_reg.aux[`DTC_AUX_CKOE1])
    else $error("unit one output enable wrong");
  a_one_clk_toggle: assert property ( // R19
    ovf1 && cko_on1 && !split0 |=> (r_reg.cko1 != $past(r_reg.cko1)) &&
    !r_reg.irq1)
    else $error("unit one clock output did not toggle quietly");
  a_clkout_hold: assert property ( // R19
    !(ovf0 && cko_on0) |=> $stable(r_reg.cko0))
    else $error("unit zero clock output moved without overflow");
  a_edge_pend_one: assert property ( // R16
    rate1 && r_reg.smp1 && !i_count_pin_one |=> r_reg.pend1)
    else $error("unit one falling edge not detected");

endmodule
